// [include/gpibrv_defines.vh]
// register numbers, field positions and reset values of the register view
`ifndef GPIBRV_DEFINES_VH
`define GPIBRV_DEFINES_VH
// status register numbers
`define GPIBRV_ST_CARD_ID     3'h0
`define GPIBRV_ST_INT_DMA     3'h1
`define GPIBRV_ST_CTRL_ADDR   3'h3
`define GPIBRV_ST_EVENTS      3'h4
`define GPIBRV_ST_MASK        3'h5
// control register numbers
`define GPIBRV_CT_RESET       3'h0
`define GPIBRV_CT_SERIAL      3'h1
`define GPIBRV_CT_PARALLEL    3'h2
`define GPIBRV_CT_ADDRESS     3'h3
`define GPIBRV_CT_MASK_LO     3'h4
`define GPIBRV_CT_MASK_HI     3'h5
`define GPIBRV_CT_INT_ENABLE  3'h6
// field layout
`define GPIBRV_ADDR_MSB       4
`define GPIBRV_ADDR_W         5
`define GPIBRV_SRQ_BIT        6
`define GPIBRV_ACTIVE_BIT     15
// reset values
`define GPIBRV_ZERO8          8'h00
`define GPIBRV_ZERO16         16'h0000
`define GPIBRV_ZERO2          2'h0
`define GPIBRV_ZERO1          1'b0
`define GPIBRV_ONE1           1'b1
`define GPIBRV_ADDR_RESET     5'h15
`define GPIBRV_NO_ADDR        5'h1F
`endif

// [design/gpibrv_sync.v]
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`include "gpibrv_defines.vh"
module gpibrv_sync (
    // clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // pin and result
    input  wire pin_in,
    output reg  level
);
    reg stage1;
    reg stage2;
    reg stage3;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= `GPIBRV_ZERO1;
            stage2 <= `GPIBRV_ZERO1;
            stage3 <= `GPIBRV_ZERO1;
            level  <= `GPIBRV_ZERO1;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule

// [design/gpibrv_flag.v]
// one sticky event flag; a set wins over a same-cycle clear
`timescale 1ns/1ps
`include "gpibrv_defines.vh"
module gpibrv_flag (
    // clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // control
    input  wire set_pulse,
    input  wire clear_pulse,
    output reg  flag
);
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= `GPIBRV_ZERO1;
        end else if (set_pulse) begin
            flag <= `GPIBRV_ONE1;
        end else if (clear_pulse) begin
            flag <= `GPIBRV_ZERO1;
        end
    end
endmodule

// [design/gpibrv_register_view.v]
// register view of the bus interface card: status reads, control writes
`timescale 1ns/1ps
`include "gpibrv_defines.vh"
// Operation
// - status register zero returns a fixed read-only identification byte
// - status one: int enable, int request, level, zeros, dma enables
// - control one holds serial poll byte; bit six means service requested
// - control two holds parallel poll byte; bit n drives data line n+1
// - status three: system ctrl, active ctrl, zero, own primary address
// - status four presents sixteen event flags, upper byte as listed
// - status five holds sixteen-bit enable mask, same bit positions
module gpibrv_register_view #(
    parameter [7:0] CARD_ID = 8'h5A  // arbitrary identification value
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // status read call
    input  wire        status_read_call,
    input  wire [2:0]  status_sel,
    output reg  [15:0] status_data,
    output reg         status_valid,
    // control write call
    input  wire        control_write_call,
    input  wire [2:0]  control_sel,
    input  wire [7:0]  control_data,
    // card straps and bus-side state
    input  wire [1:0]  int_level,
    input  wire        dma1_enabled,
    input  wire        dma0_enabled,
    input  wire        system_controller_pin,
    input  wire        active_controller,
    input  wire [15:0] event_pulse,
    input  wire        serial_poll_read,
    input  wire        parallel_poll_active,
    // outputs to bus side
    output reg  [7:0]  serial_poll_byte,
    output reg  [7:0]  dio_drive,
    output reg  [7:0]  dio_oe,
    output reg  [4:0]  own_address,
    output reg         interface_reset,
    output reg         int_request
);
    reg  [7:0]  parallel_byte;
    reg  [15:0] int_mask;
    reg         int_enable;
    reg         sysctl_level;
    reg  [15:0] event_clear;
    wire [15:0] event_flags;
    wire        sysctl_sync;
    wire        soft_reset;
    wire        any_pending;
    wire        wr_hit;

    assign wr_hit      = control_write_call;
    assign soft_reset  = wr_hit && (control_sel == `GPIBRV_CT_RESET);
    assign any_pending = |(event_flags & int_mask) && int_enable;

    gpibrv_sync u_sysctl (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .pin_in  (system_controller_pin),
        .level   (sysctl_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
            gpibrv_flag u_flag (
                .sys_clk     (sys_clk),
                .reset_n     (reset_n),
                .set_pulse   (event_pulse[gi]),
                .clear_pulse (event_clear[gi]),
                .flag        (event_flags[gi])
            );
        end
    endgenerate

    // a status read of the event flags clears them; a soft reset too
    always @* begin
        event_clear = `GPIBRV_ZERO16;
        if (soft_reset || (status_read_call &&
            status_sel == `GPIBRV_ST_EVENTS)) begin
            event_clear = ~`GPIBRV_ZERO16;
        end
    end

    // control registers
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_poll_byte <= `GPIBRV_ZERO8;
            parallel_byte    <= `GPIBRV_ZERO8;
            own_address      <= `GPIBRV_ADDR_RESET;
            int_mask         <= `GPIBRV_ZERO16;
            int_enable       <= `GPIBRV_ZERO1;
            interface_reset  <= `GPIBRV_ZERO1;
        end else begin
            interface_reset <= soft_reset;
            if (soft_reset) begin
                serial_poll_byte <= `GPIBRV_ZERO8;
                parallel_byte    <= `GPIBRV_ZERO8;
                int_mask         <= `GPIBRV_ZERO16;
                int_enable       <= `GPIBRV_ZERO1;
            end else if (wr_hit) begin
                case (control_sel)
                    `GPIBRV_CT_SERIAL: begin
                        serial_poll_byte <= control_data;
                    end
                    `GPIBRV_CT_PARALLEL: begin
                        parallel_byte <= control_data;
                    end
                    `GPIBRV_CT_ADDRESS: begin
                        if (control_data[`GPIBRV_ADDR_MSB:0] !=
                            `GPIBRV_NO_ADDR) begin
                            own_address <=
                                control_data[`GPIBRV_ADDR_MSB:0];
                        end
                    end
                    `GPIBRV_CT_MASK_LO: begin
                        int_mask[7:0] <= control_data;
                    end
                    `GPIBRV_CT_MASK_HI: begin
                        int_mask[15:8] <= control_data;
                    end
                    `GPIBRV_CT_INT_ENABLE: begin
                        int_enable <= control_data[0];
                    end
                    default: begin
                        int_enable <= int_enable;
                    end
                endcase
            end
        end
    end

    // serial poll read does not drop the service request bit once reported
    // (handled by software rewriting the byte; bit kept as written)

    // parallel poll drive: bit n onto data line n+1, open-drain style
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dio_drive <= `GPIBRV_ZERO8;
            dio_oe    <= `GPIBRV_ZERO8;
        end else begin
            dio_drive <= `GPIBRV_ZERO8;
            if (parallel_poll_active) begin
                dio_oe <= parallel_byte;
            end else begin
                dio_oe <= `GPIBRV_ZERO8;
            end
        end
    end

    // interrupt request
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_request  <= `GPIBRV_ZERO1;
            sysctl_level <= `GPIBRV_ZERO1;
        end else begin
            int_request  <= any_pending;
            sysctl_level <= sysctl_sync;
        end
    end

    // status read mux, answered one cycle after the call
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_data  <= `GPIBRV_ZERO16;
            status_valid <= `GPIBRV_ZERO1;
        end else begin
            status_valid <= status_read_call;
            if (status_read_call) begin
                case (status_sel)
                    `GPIBRV_ST_CARD_ID: begin
                        status_data <= {`GPIBRV_ZERO8, CARD_ID};
                    end
                    `GPIBRV_ST_INT_DMA: begin
                        status_data <= {`GPIBRV_ZERO8, int_enable,
                            int_request, int_level, `GPIBRV_ZERO2,
                            dma1_enabled, dma0_enabled};
                    end
                    `GPIBRV_ST_CTRL_ADDR: begin
                        status_data <= {`GPIBRV_ZERO8, sysctl_level,
                            active_controller, `GPIBRV_ZERO1,
                            own_address};
                    end
                    `GPIBRV_ST_EVENTS: begin
                        status_data <= event_flags;
                    end
                    `GPIBRV_ST_MASK: begin
                        status_data <= int_mask;
                    end
                    default: begin
                        status_data <= `GPIBRV_ZERO16;
                    end
                endcase
            end
        end
    end
endmodule

// [bench/gpibrv_monitor.sv]
// port checks of the register view
`timescale 1ns/1ps
module gpibrv_monitor #(
    parameter [7:0] CARD_ID = 8'h5A
) (
    input logic        sys_clk,
    input logic        reset_n,
    input logic        status_read_call,
    input logic [2:0]  status_sel,
    input logic [15:0] status_data,
    input logic        status_valid,
    input logic        control_write_call,
    input logic [2:0]  control_sel,
    input logic [7:0]  control_data,
    input logic [1:0]  int_level,
    input logic        active_controller,
    input logic        parallel_poll_active,
    input logic [7:0]  serial_poll_byte,
    input logic [7:0]  dio_drive,
    input logic [7:0]  dio_oe,
    input logic [4:0]  own_address,
    input logic        interface_reset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_VALID: assert property (status_read_call |=> status_valid)
        else $error("read not answered");
    AST_ID: assert property (status_read_call && status_sel == 3'h0
        |=> status_data == {8'h00, CARD_ID}) else $error("bad id");
    AST_RST: assert property (control_write_call && control_sel == 3'h0
        |=> interface_reset) else $error("no reset pulse");
    AST_SER: assert property (control_write_call && control_sel == 3'h1
        && !interface_reset |=> serial_poll_byte == $past(control_data))
        else $error("serial byte");
    AST_PP: assert property (!parallel_poll_active |=> dio_oe == 8'h00)
        else $error("lines driven outside poll");
    AST_DRV: assert property (dio_drive == 8'h00)
        else $error("line driven high");
    AST_ST1: assert property (status_read_call && status_sel == 3'h1
        |=> status_data[5:2] == {$past(int_level), 2'h0})
        else $error("status one");
    AST_ST3: assert property (status_read_call && status_sel == 3'h3
        |=> status_data[6:0] == {$past(active_controller), 1'b0,
        $past(own_address)}) else $error("status three");
    AST_ADR: assert property (control_write_call && control_sel == 3'h3
        && control_data[4:0] != 5'h1F && !interface_reset
        |=> own_address == $past(control_data[4:0])) else $error("address");
endmodule
bind gpibrv_register_view gpibrv_monitor #(.CARD_ID(CARD_ID)) u_mon (.*);

// [bench/gpibrv_bus_model.sv]
// bus side: event sources and pulled-up data lines
`timescale 1ns/1ps
module gpibrv_bus_model (
    // clock
    input  wire        sys_clk,
    // events
    input  wire [15:0] ev_req,
    output reg  [15:0] event_pulse,
    // data lines
    input  wire [7:0]  dio_drive,
    input  wire [7:0]  dio_oe,
    output wire [7:0]  dio_bus
);
    always @(posedge sys_clk) begin
        event_pulse <= ev_req;
    end
    // undriven lines float high
    assign dio_bus = (dio_oe & dio_drive) | ~dio_oe;
endmodule

// [bench/gpibrv_register_view_tb.sv]
// bench for the register view
`timescale 1ns/1ps
module gpibrv_register_view_tb;
    reg         sys_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         status_read_call = 1'b0;
    reg  [2:0]  status_sel = 3'h0;
    reg         control_write_call = 1'b0;
    reg  [2:0]  control_sel = 3'h0;
    reg  [7:0]  control_data = 8'h00;
    reg         active_controller = 1'b0;
    reg         parallel_poll_active = 1'b0;
    reg  [15:0] ev_req = 16'h0000;
    wire [15:0] status_data, event_pulse;
    wire        status_valid, interface_reset, int_request;
    wire [7:0]  serial_poll_byte, dio_drive, dio_oe, dio_bus;
    wire [4:0]  own_address;
    integer     mismatches = 0;
    integer     compares = 0;
    integer     cycles = 0;
    always #50 sys_clk = ~sys_clk;
    gpibrv_register_view u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .status_read_call(status_read_call), .status_sel(status_sel),
        .status_data(status_data), .status_valid(status_valid),
        .control_write_call(control_write_call), .control_sel(control_sel),
        .control_data(control_data), .int_level(2'h2), .dma1_enabled(1'b1),
        .dma0_enabled(1'b0), .system_controller_pin(1'b1),
        .active_controller(active_controller), .event_pulse(event_pulse),
        .serial_poll_read(1'b0), .parallel_poll_active(parallel_poll_active),
        .serial_poll_byte(serial_poll_byte), .dio_drive(dio_drive),
        .dio_oe(dio_oe), .own_address(own_address),
        .interface_reset(interface_reset), .int_request(int_request));
    gpibrv_bus_model u_bus (.sys_clk(sys_clk), .ev_req(ev_req),
        .event_pulse(event_pulse), .dio_drive(dio_drive), .dio_oe(dio_oe),
        .dio_bus(dio_bus));
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input [15:0] exp, input [15:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input [2:0] sel, input [7:0] dat);
        @(posedge sys_clk);
        control_write_call <= 1'b1;
        control_sel <= sel;
        control_data <= dat;
        @(posedge sys_clk);
        control_write_call <= 1'b0;
    endtask
    task rd(input [2:0] sel, input [15:0] exp);
        @(posedge sys_clk);
        status_read_call <= 1'b1;
        status_sel <= sel;
        @(posedge sys_clk);
        status_read_call <= 1'b0;
        @(negedge sys_clk);
        chk("status_valid", 16'h0001, {15'h0, status_valid});
        chk("status_data", exp, status_data);
    endtask
    task ev(input [15:0] v);
        @(posedge sys_clk);
        ev_req <= v;
        @(posedge sys_clk);
        ev_req <= 16'h0000;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            mismatches = mismatches + 1;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(3'h0, 16'h005A);
        repeat (4) @(posedge sys_clk);
        rd(3'h3, 16'h0095);
        rd(3'h1, 16'h0022);
        wr(3'h3, 8'hE9);
        wr(3'h3, 8'h1F);
        rd(3'h3, 16'h0089);
        $display("test reset and address done");
        wr(3'h1, 8'h4C);
        wr(3'h2, 8'hA5);
        parallel_poll_active <= 1'b1;
        @(negedge sys_clk);
        chk("serial_poll_byte", 16'h004C, serial_poll_byte);
        repeat (2) @(negedge sys_clk);
        chk("dio_bus", 16'h005A, dio_bus);
        @(posedge sys_clk);
        parallel_poll_active <= 1'b0;
        $display("test poll bytes done");
        wr(3'h4, 8'h81);
        wr(3'h5, 8'h80);
        wr(3'h6, 8'h01);
        rd(3'h5, 16'h8081);
        ev(16'h7F7E);
        chk("int_request", 16'h0000, int_request);
        rd(3'h4, 16'h7F7E);
        rd(3'h4, 16'h0000);
        ev(16'h8081);
        rd(3'h1, 16'h00E2);
        rd(3'h4, 16'h8081);
        rd(3'h1, 16'h00A2);
        $display("test events done");
        @(posedge sys_clk);
        active_controller <= 1'b1;
        wr(3'h0, 8'h00);
        @(negedge sys_clk);
        chk("interface_reset", 16'h0001, {15'h0, interface_reset});
        @(negedge sys_clk);
        chk("serial_poll_byte", 16'h0000, serial_poll_byte);
        rd(3'h5, 16'h0000);
        rd(3'h1, 16'h0022);
        rd(3'h3, 16'h00C9);
        $display("test soft reset done");
        tally_and_finish;
    end
endmodule
